// ===== design/reload_pwm_timer.sv
// Eight-bit auto-reload timer with four PWM outputs and two input captures.
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "reload_pwm_defines.svh"

module reload_pwm_timer
    import reload_pwm_pkg::*;
#(
    parameter int PWM_CHANNELS = 4,
    parameter int CAP_CHANNELS = 2
) (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [9:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // External prescaler clock input.
    input  wire logic        ext_clock_i,
    // Capture inputs.
    input  wire logic [1:0]  capture_input_pin_i,
    // PWM pins.
    output logic      [3:0]  wave_output_pin_o,
    output logic      [3:0]  wave_output_pin_oe_o,
    // Interrupt requests.
    output logic             overflow_irq_o,
    output logic      [1:0]  capture_irq_o
);

    // The register map holds exactly four duty registers and two capture registers.
    generate
        if (PWM_CHANNELS != 4) begin : g_bad_pwm
            $error("reload_pwm_timer serves exactly four PWM channels.");
        end
        if (CAP_CHANNELS != 2) begin : g_bad_cap
            $error("reload_pwm_timer serves exactly two capture channels.");
        end
    endgenerate

    byte_t      duty_reg [4];
    byte_t      shadow_reg [4];
    byte_t      wave_ctrl_reg;
    byte_t      csr_reg;
    byte_t      counter_reg;
    byte_t      reload_reg;
    logic [5:0] cap_cs_reg;
    byte_t      capture_reg [2];
    logic [6:0] prescaler_reg;
    logic [1:0] ext_sync_reg;
    logic       ext_prev_reg;
    logic [1:0] cap_sync1_reg;
    logic [1:0] cap_sync2_reg;
    logic [1:0] cap_prev_reg;
    bus_state_t bus_state_reg;

    // Bus access decode; the register index is word address bits adr_i[7:2], and adr_i[9:8] are ignored.
    logic  req;
    logic  wr_en;
    logic  rd_en;
    byte_t idx;
    byte_t wdata;
    assign req   = cyc_i && stb_i && (bus_state_reg == BUS_IDLE);
    assign wr_en = req && we_i && sel_i[0];
    assign rd_en = req && !we_i;
    assign idx   = {2'b00, adr_i[7:2]};
    assign wdata = dat_i[7:0];

    function automatic logic hit(input byte_t a, input byte_t r);
        hit = (a == r);
    endfunction : hit

    // Per-register strobes, decoded once and shared by the register processes.
    logic       wr_counter;
    logic       wr_csr;
    logic       wr_wave;
    logic       wr_reload;
    logic       wr_cap_cs;
    logic       rd_csr;
    logic [1:0] rd_capture;
    assign wr_counter    = wr_en && hit(idx, `IDX_COUNTER);
    assign wr_csr        = wr_en && hit(idx, `IDX_TIMER_CS);
    assign wr_wave       = wr_en && hit(idx, `IDX_WAVE_CTRL);
    assign wr_reload     = wr_en && hit(idx, `IDX_RELOAD);
    assign wr_cap_cs     = wr_en && hit(idx, `IDX_CAPTURE_CS);
    assign rd_csr        = rd_en && hit(idx, `IDX_TIMER_CS);
    assign rd_capture[0] = rd_en && hit(idx, `IDX_CAPTURE_CH1);
    assign rd_capture[1] = rd_en && hit(idx, `IDX_CAPTURE_CH2);

    // Prescaler tick selection from the selected input clock.
    logic       input_tick;
    logic       count_tick;
    logic       overflow;
    logic       force_wr;
    logic [6:0] div_mask;
    logic [2:0] div_sel;
    assign div_sel    = csr_reg[`CS_DIV_LSB +: 3];
    assign input_tick = csr_reg[`CS_EXT_CLK_BIT] ? (ext_sync_reg[1] && !ext_prev_reg) : 1'b1;
    assign div_mask   = 7'(({7'h00, 1'b1} << div_sel) - 8'h01);
    assign count_tick = csr_reg[`CS_RUN_BIT] && input_tick
                        && ((prescaler_reg & div_mask) == div_mask);
    assign overflow   = count_tick && (counter_reg == `COUNT_TOP);
    assign force_wr   = wr_csr && wdata[`CS_FORCE_BIT];

    // External clock synchroniser; reset fills it with the pin level so no false edge follows.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_sync_reg <= {2{ext_clock_i}};
            ext_prev_reg <= ext_clock_i;
        end else begin
            ext_sync_reg <= {ext_sync_reg[0], ext_clock_i};
            ext_prev_reg <= ext_sync_reg[1];
        end
    end

    // Prescaler counts selected input ticks and restarts on any counter initialisation.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prescaler_reg <= 7'h00;
        end else if (force_wr || wr_counter) begin
            prescaler_reg <= 7'h00;
        end else if (csr_reg[`CS_RUN_BIT] && input_tick) begin
            prescaler_reg <= prescaler_reg + 7'h01;
        end
    end

    // Counter: software load, forced reload, overflow reload, then increment.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_reg <= `REG_RESET;
        end else if (wr_counter) begin
            counter_reg <= wdata;
        end else if (force_wr) begin
            counter_reg <= reload_reg;
        end else if (overflow) begin
            counter_reg <= reload_reg;
        end else if (count_tick) begin
            counter_reg <= counter_reg + 8'h01;
        end
    end

    // Control fields of the control/status register; the force bit is never stored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            csr_reg[7:1] <= 7'h00;
        end else begin
            if (wr_csr) begin
                csr_reg[7:3]            <= wdata[7:3];
                csr_reg[`CS_OVF_IE_BIT] <= wdata[`CS_OVF_IE_BIT];
            end
            csr_reg[`CS_FORCE_BIT] <= 1'b0;
        end
    end

    // Overflow flag; a set in the same cycle wins over the read clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            csr_reg[`CS_OVF_BIT] <= 1'b0;
        end else if (overflow) begin
            csr_reg[`CS_OVF_BIT] <= 1'b1;
        end else if (rd_csr) begin
            csr_reg[`CS_OVF_BIT] <= 1'b0;
        end
    end

    // Output enables and polarities.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wave_ctrl_reg <= `REG_RESET;
        end else if (wr_wave) begin
            wave_ctrl_reg <= wdata;
        end
    end

    // Auto-reload value.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_reg <= `REG_RESET;
        end else if (wr_reload) begin
            reload_reg <= wdata;
        end
    end

    // Duty registers, shadow compares and pin levels, one set per channel.
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_pwm
            // Software-visible duty register.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    duty_reg[ch] <= `REG_RESET;
                end else if (wr_en && hit(idx, 8'(`IDX_DUTY_CH0 - ch))) begin
                    duty_reg[ch] <= wdata;
                end
            end
            // Shadow compare, loaded only at reload so duty changes stay glitch-free.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    shadow_reg[ch] <= `REG_RESET;
                end else if (overflow || force_wr) begin
                    shadow_reg[ch] <= duty_reg[ch];
                end
            end
            // Level follows counter against compare; polarity applies live.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    wave_output_pin_o[ch] <= 1'b0;
                end else if (overflow) begin
                    wave_output_pin_o[ch] <= (reload_reg <= duty_reg[ch])
                                             ^ wave_ctrl_reg[ch];
                end else begin
                    wave_output_pin_o[ch] <= (counter_reg <= shadow_reg[ch])
                                             ^ wave_ctrl_reg[ch];
                end
            end
            assign wave_output_pin_oe_o[ch] = wave_ctrl_reg[4 + ch];
        end
    endgenerate

    // Capture channels: sync, edge detect, latch, flag.
    // Reset fills the chain with the pin levels so an idle-high pin gives no false edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_sync1_reg <= capture_input_pin_i;
            cap_sync2_reg <= capture_input_pin_i;
            cap_prev_reg  <= capture_input_pin_i;
        end else begin
            cap_sync1_reg <= capture_input_pin_i;
            cap_sync2_reg <= cap_sync1_reg;
            cap_prev_reg  <= cap_sync2_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_cs_reg[5:2] <= 4'h0;
        end else if (wr_cap_cs) begin
            cap_cs_reg[5:2] <= wdata[5:2];
        end
    end

    generate
        for (ch = 0; ch < 2; ch++) begin : g_cap
            logic edge_seen;
            logic capture_take;
            assign edge_seen = cap_cs_reg[`CAP_EDGE_LSB + ch]
                               ? (cap_sync2_reg[ch] && !cap_prev_reg[ch])
                               : (!cap_sync2_reg[ch] && cap_prev_reg[ch]);
            assign capture_take = edge_seen && !cap_cs_reg[`CAP_FLAG_LSB + ch];
            // Latched counter value; held while the flag blocks new captures.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    capture_reg[ch] <= `REG_RESET;
                end else if (capture_take) begin
                    capture_reg[ch] <= counter_reg;
                end
            end
            // Capture flag, cleared by reading this channel's capture register.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cap_cs_reg[ch] <= 1'b0;
                end else if (capture_take) begin
                    cap_cs_reg[ch] <= 1'b1;
                end else if (rd_capture[ch]) begin
                    cap_cs_reg[ch] <= 1'b0;
                end
            end
            assign capture_irq_o[ch] = cap_cs_reg[ch] && cap_cs_reg[`CAP_IE_LSB + ch];
        end
    endgenerate

    assign overflow_irq_o = csr_reg[`CS_OVF_BIT] && csr_reg[`CS_OVF_IE_BIT];

    // Read multiplexer and one-cycle acknowledge.
    byte_t rd_value;
    always_comb begin
        rd_value = 8'h00;
        if (hit(idx, `IDX_DUTY_CH3)) begin
            rd_value = duty_reg[3];
        end else if (hit(idx, `IDX_DUTY_CH2)) begin
            rd_value = duty_reg[2];
        end else if (hit(idx, `IDX_DUTY_CH1)) begin
            rd_value = duty_reg[1];
        end else if (hit(idx, `IDX_DUTY_CH0)) begin
            rd_value = duty_reg[0];
        end else if (hit(idx, `IDX_WAVE_CTRL)) begin
            rd_value = wave_ctrl_reg;
        end else if (hit(idx, `IDX_TIMER_CS)) begin
            rd_value = csr_reg & 8'hfb;
        end else if (hit(idx, `IDX_COUNTER)) begin
            rd_value = counter_reg;
        end else if (hit(idx, `IDX_RELOAD)) begin
            rd_value = reload_reg;
        end else if (hit(idx, `IDX_CAPTURE_CS)) begin
            rd_value = {2'b00, cap_cs_reg};
        end else if (hit(idx, `IDX_CAPTURE_CH1)) begin
            rd_value = capture_reg[0];
        end else if (hit(idx, `IDX_CAPTURE_CH2)) begin
            rd_value = capture_reg[1];
        end
    end

    // Bus state: one answered cycle, then a forced idle cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state_reg <= BUS_IDLE;
        end else begin
            case (bus_state_reg)
                BUS_IDLE: begin
                    if (req) begin
                        bus_state_reg <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    bus_state_reg <= BUS_IDLE;
                end
                default: begin
                    bus_state_reg <= BUS_IDLE;
                end
            endcase
        end
    end

    // Acknowledge pulses for one cycle after a request is taken.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // Read data is captured with the request and held until the next access.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req) begin
            dat_o <= {24'h00_0000, rd_value};
        end
    end

endmodule : reload_pwm_timer
`default_nettype wire

// ===== design/reload_pwm_defines.svh
// Register offsets, field positions, reset values and timing counts of the reload PWM timer.
// Behaviour
// - Force-reload bit always reads as zero
// - Force-reload loads reload value, clears prescaler
// - Overflow interrupt raised only when enabled
// - Overflow sets flag; status read clears it
// - Counter register reads live, writes load
// - Overflow reloads counter and sets polarity levels
// - Output-enable bits connect each channel's pin
// - Output high while counter not above compare
// - Polarity change inverts output at once
// - Duty register sets compare, reload first edge
// - Capture status upper two bits read zero
// - Edge select: zero falling, one rising
// - Capture interrupt enable gates each channel
// - Capture sets flag; data read clears it
// - Capture register holds latched counter value
// - All registers reset to zero
// - Shadow compare loaded from duty at overflow
// - Capture blocked until flag cleared by read
// - Divider field divides input clock by power of two
`ifndef RELOAD_PWM_DEFINES_SVH
`define RELOAD_PWM_DEFINES_SVH

`define IDX_DUTY_CH3     8'h31
`define IDX_DUTY_CH2     8'h32
`define IDX_DUTY_CH1     8'h33
`define IDX_DUTY_CH0     8'h34
`define IDX_WAVE_CTRL    8'h35
`define IDX_TIMER_CS     8'h36
`define IDX_COUNTER      8'h37
`define IDX_RELOAD       8'h38
`define IDX_CAPTURE_CS   8'h39
`define IDX_CAPTURE_CH1  8'h3a
`define IDX_CAPTURE_CH2  8'h3b

`define REG_RESET        8'h00
`define CS_EXT_CLK_BIT   7
`define CS_DIV_LSB       4
`define CS_RUN_BIT       3
`define CS_FORCE_BIT     2
`define CS_OVF_IE_BIT    1
`define CS_OVF_BIT       0
`define CAP_EDGE_LSB     4
`define CAP_IE_LSB       2
`define CAP_FLAG_LSB     0
`define COUNT_TOP        8'hff

`endif

// ===== design/reload_pwm_pkg.sv
// Types shared by the reload PWM timer.
package reload_pwm_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;
endpackage : reload_pwm_pkg

// ===== tb/reload_pwm_monitor.sv
// Concurrent checks on the reload PWM timer ports.
`timescale 1ns/100ps
`default_nettype none
module reload_pwm_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [9:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic [3:0]  wave_output_pin_oe_o,
    input wire logic        overflow_irq_o,
    input wire logic [1:0]  capture_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       req;
    logic       wr_take;
    logic [5:0] idx;
    assign req = cyc_i && stb_i;
    assign wr_take = req && we_i && sel_i[0] && !ack_o;
    assign idx = adr_i[7:2];
    property p_ack_answer;
        req && !ack_o && !$past(ack_o) |=> ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack one cycle after request");
    property p_force_zero;
        ack_o && !we_i && idx == 6'h36 |-> !dat_o[2];
    endproperty
    a_force_zero: assert property (p_force_zero) else $error("force bit read as one");
    property p_cap_reserved;
        ack_o && !we_i && idx == 6'h39 |-> dat_o[7:6] == 2'b00;
    endproperty
    a_cap_reserved: assert property (p_cap_reserved) else $error("reserved bits set");
    property p_ovf_clear;
        $fell(overflow_irq_o) |-> $past(req) || ack_o;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow irq fell unasked");
    property p_cap_clear;
        $fell(capture_irq_o[0]) || $fell(capture_irq_o[1]) |-> $past(req) || ack_o;
    endproperty
    a_cap_clear: assert property (p_cap_clear) else $error("capture irq fell unasked");
    property p_oe_write;
        wr_take && idx == 6'h35 |=> wave_output_pin_oe_o == $past(dat_i[7:4]);
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("output enable mismatch");
    property p_irq_masked;
        wr_take && idx == 6'h36 && !dat_i[1] |=> !overflow_irq_o [*2];
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked overflow irq");
    property p_cap_masked;
        wr_take && idx == 6'h39 && dat_i[3:2] == 2'b00 |=> capture_irq_o == 2'b00;
    endproperty
    a_cap_masked: assert property (p_cap_masked) else $error("masked capture irq");
    c_ovf: cover property ($rose(overflow_irq_o));
    c_cap: cover property ($rose(capture_irq_o[1]));
    c_wave: cover property (wr_take && idx == 6'h35);
endmodule : reload_pwm_monitor
bind reload_pwm_timer reload_pwm_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .wave_output_pin_oe_o, .overflow_irq_o,
    .capture_irq_o);
`default_nettype wire

// ===== tb/capture_source_model.sv
// Far-side model that drives the capture inputs and the external prescaler clock.
`timescale 1ns/100ps
`default_nettype none
module capture_source_model (
    input  wire logic       clk_i,
    input  wire logic [1:0] level_i,
    input  wire logic       ext_level_i,
    output logic      [1:0] capture_input_pin_o,
    output logic            ext_clock_o
);
    // Levels change just after a rising edge, as a clean external driver would.
    always_ff @(posedge clk_i) begin
        capture_input_pin_o <= level_i;
        ext_clock_o         <= ext_level_i;
    end
endmodule : capture_source_model
`default_nettype wire

// ===== tb/auto_reload_pwm_timer_tb.sv
// Self-checking bench for the reload PWM timer.
`timescale 1ns/100ps
`default_nettype none
module auto_reload_pwm_timer_tb
    import reload_pwm_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [9:0]  adr_i = 10'h000;
    logic [31:0] dat_i = 32'h0;
    logic [1:0]  level = 2'b10;
    logic [3:0]  sel = 4'h1;
    logic        ext_level = 1'b0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic        ack_o;
    logic        ext_clock_i;
    logic        overflow_irq_o;
    logic [1:0]  capture_input_pin_i;
    logic [1:0]  capture_irq_o;
    logic [3:0]  wave_output_pin_o;
    logic [3:0]  wave_output_pin_oe_o;
    int          n_mismatch = 0;
    int          check_count = 0;
    always #10 clk_i = ~clk_i;
    reload_pwm_timer u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(sel),
        .dat_i, .dat_o, .ack_o, .ext_clock_i, .capture_input_pin_i, .wave_output_pin_o,
        .wave_output_pin_oe_o, .overflow_irq_o, .capture_irq_o);
    capture_source_model u_src (.clk_i, .level_i(level), .ext_level_i(ext_level),
        .capture_input_pin_o(capture_input_pin_i), .ext_clock_o(ext_clock_i));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic acc(input logic w, input byte_t a, input byte_t d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {a, 2'b00};
        dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : acc
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rdchk(input byte_t a, input byte_t e);
        acc(1'b0, a, 8'h00);
        check(rd, {24'h0, e});
    endtask : rdchk
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        final_report;
    end
    initial begin
        tick(16);
        rst_i <= 1'b0;
        for (int a = 8'h31; a <= 8'h3b; a++) rdchk(byte_t'(a), 8'h00);
        sel <= 4'h0;
        acc(1'b1, 8'h31, 8'h77);
        sel <= 4'h1;
        rdchk(8'h31, 8'h00);
        acc(1'b1, 8'h3f, 8'h5a);
        rdchk(8'h3f, 8'h00);
        acc(1'b1, 8'h38, 8'hf0);
        acc(1'b1, 8'h37, 8'h10);
        rdchk(8'h37, 8'h10);
        acc(1'b1, 8'h36, 8'h04);
        rdchk(8'h37, 8'hf0);
        rdchk(8'h36, 8'h00);
        acc(1'b1, 8'h36, 8'h0a);
        for (int i = 0; i < 100 && overflow_irq_o !== 1'b1; i++) @(posedge clk_i);
        check(overflow_irq_o, 1'b1);
        rdchk(8'h36, 8'h0b);
        check(overflow_irq_o, 1'b0);
        acc(1'b1, 8'h36, 8'h08);
        tick(40);
        check(overflow_irq_o, 1'b0);
        rdchk(8'h36, 8'h09);
        acc(1'b0, 8'h37, 8'h00);
        check(rd[7:0] >= 8'hf0, 1'b1);
        acc(1'b1, 8'h36, 8'h00);
        acc(1'b1, 8'h37, 8'h00);
        acc(1'b1, 8'h36, 8'h38);
        tick(80);
        acc(1'b1, 8'h36, 8'h00);
        acc(1'b0, 8'h37, 8'h00);
        check(rd[7:0] inside {[8'h09:8'h0b]}, 1'b1);
        acc(1'b1, 8'h37, 8'h00);
        acc(1'b1, 8'h36, 8'h88);
        repeat (5) begin
            ext_level <= 1'b1;
            tick(3);
            ext_level <= 1'b0;
            tick(3);
        end
        tick(4);
        acc(1'b1, 8'h36, 8'h00);
        rdchk(8'h37, 8'h05);
        acc(1'b1, 8'h38, 8'h00);
        acc(1'b1, 8'h34, 8'h80);
        acc(1'b1, 8'h35, 8'hf0);
        acc(1'b1, 8'h36, 8'h04);
        acc(1'b1, 8'h37, 8'h40);
        tick(3);
        check(wave_output_pin_o, 4'b0001);
        check(wave_output_pin_oe_o, 4'hf);
        acc(1'b1, 8'h35, 8'hff);
        tick(2);
        check(wave_output_pin_o, 4'b1110);
        acc(1'b1, 8'h35, 8'h50);
        check(wave_output_pin_oe_o, 4'b0101);
        acc(1'b1, 8'h34, 8'h20);
        tick(2);
        check(wave_output_pin_o, 4'b0001);
        acc(1'b1, 8'h36, 8'h04);
        acc(1'b1, 8'h37, 8'h40);
        tick(3);
        check(wave_output_pin_o, 4'b0000);
        acc(1'b1, 8'h37, 8'h55);
        acc(1'b1, 8'h39, 8'h1c);
        level <= 2'b11;
        tick(8);
        check(capture_irq_o, 2'b01);
        rdchk(8'h39, 8'h1d);
        acc(1'b1, 8'h37, 8'h66);
        level <= 2'b10;
        tick(4);
        level <= 2'b11;
        tick(8);
        rdchk(8'h3a, 8'h55);
        check(capture_irq_o, 2'b00);
        level <= 2'b00;
        tick(8);
        check(capture_irq_o, 2'b10);
        rdchk(8'h3b, 8'h66);
        rdchk(8'h39, 8'h1c);
        final_report;
    end
endmodule : auto_reload_pwm_timer_tb
`default_nettype wire
